// File: design/mpb_port.sv
// Function
// - Pins whose name ends in _n are asserted low and every other pin is asserted high.
// - read_write_dir is high for a read from the external device and low for a write.
// - In wait mode an asserted stretch_or_done_n holds the strobe phase open.
// - In acknowledge mode an asserted stretch_or_done_n ends the current transaction.
// - read_output_strobe_n is asserted exactly while the external device must drive data.
// - write_strobe_n is asserted to write data into the selected external device.
// - Four device selects exist and only the addressed one is asserted.
// - A 22-bit address is driven on dedicated pins, bits 25 to 22 on a separate group.
// - Data moves on a two-way 8-bit bus that is input only during cold reset.
// - xcvr_direction_n steers an external transceiver whose A side faces this port.
// - xcvr_output_enable_n enables the external buffer only while the bus is in use.
`timescale 1ns/1ps
module mpb_port (
  input wire logic clk,
  input wire logic srst,
  input wire logic cold_reset,
  input wire logic wait_is_ack,
  input wire logic req_valid,
  output logic req_ready,
  input wire mpb_pkg::mpb_req_type req,
  output logic rsp_valid,
  output mpb_pkg::mpb_rsp_type rsp,
  output logic [mpb_pkg::DATA_W-1:0] boot_vector,
  output logic boot_valid,
  output logic [mpb_pkg::CS_COUNT-1:0] device_select_n,
  output logic [mpb_pkg::ADDR_W-1:0] periph_address,
  output logic [mpb_pkg::ADDR_HI_W-1:0] periph_address_hi,
  input wire logic [mpb_pkg::DATA_W-1:0] periph_data_in,
  output logic [mpb_pkg::DATA_W-1:0] periph_data_out,
  output logic periph_data_oe_n,
  output logic read_write_dir,
  output logic read_output_strobe_n,
  output logic write_strobe_n,
  output logic xcvr_direction_n,
  output logic xcvr_output_enable_n,
  input wire logic stretch_or_done_n
);
  import mpb_pkg::*;

  mpb_state_type state;
  mpb_state_type next_state;
  mpb_req_type cur;
  logic phase_load;
  logic [CNT_W-1:0] phase_len;
  logic phase_done;
  logic [CNT_W-1:0] strobe_age;
  logic timed_out;
  logic stretch;
  logic strobe_end;

  // input pin polarity is resolved here, internal logic is active high
  assign stretch = !stretch_or_done_n;
  assign timed_out = (strobe_age >= TIMEOUT_CYC);
  assign req_ready = (state == MPB_IDLE) && !cold_reset;

  always_comb begin
    if (timed_out) begin
      strobe_end = 1'b1;
    end else if (wait_is_ack) begin
      strobe_end = stretch;
    end else begin
      strobe_end = phase_done && !stretch;
    end
  end

  always_comb begin
    next_state = state;
    phase_load = 1'b0;
    phase_len = SETUP_CYC;
    unique case (state)
      MPB_IDLE: begin
        if (req_valid && req_ready) begin
          next_state = MPB_SETUP;
          phase_load = 1'b1;
          phase_len = SETUP_CYC;
        end
      end
      MPB_SETUP: begin
        if (phase_done) begin
          next_state = MPB_STROBE;
          phase_load = 1'b1;
          phase_len = STROBE_CYC;
        end
      end
      MPB_STROBE: begin
        if (strobe_end) begin
          next_state = MPB_HOLD;
          phase_load = 1'b1;
          phase_len = HOLD_CYC;
        end
      end
      MPB_HOLD: begin
        if (phase_done) begin
          next_state = MPB_IDLE;
        end
      end
    endcase
  end

  mpb_phase_timer u_timer (
    .clk(clk),
    .srst(srst),
    .load(phase_load),
    .length(phase_len),
    .done(phase_done)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= MPB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur <= '0;
    end else if (req_valid && req_ready) begin
      cur <= req;
    end
  end

  // guards against a device that never acknowledges
  always_ff @(posedge clk) begin
    if (srst) begin
      strobe_age <= '0;
    end else if (state != MPB_STROBE) begin
      strobe_age <= '0;
    end else if (!timed_out) begin
      strobe_age <= strobe_age + CNT_W'(1);
    end
  end

  // pins are registered from next_state so strobes change cleanly on the edge
  always_ff @(posedge clk) begin
    if (srst) begin
      device_select_n <= CS_IDLE_N;
      xcvr_output_enable_n <= 1'b1;
    end else if (next_state == MPB_IDLE) begin
      device_select_n <= CS_IDLE_N;
      xcvr_output_enable_n <= 1'b1;
    end else begin
      device_select_n <= ~(CS_COUNT'(1) << cur_sel(next_state));
      xcvr_output_enable_n <= 1'b0;
    end
  end

  function automatic logic [CS_IDX_W-1:0] cur_sel(input mpb_state_type s);
    cur_sel = (state == MPB_IDLE && s != MPB_IDLE) ? req.select : cur.select;
  endfunction

  logic nx_write;
  assign nx_write = (state == MPB_IDLE) ? req.write : cur.write;

  always_ff @(posedge clk) begin
    if (srst) begin
      periph_address <= '0;
      periph_address_hi <= '0;
    end else if (req_valid && req_ready) begin
      periph_address <= req.addr;
      periph_address_hi <= req.addr_hi;
    end
  end

  // idle level is read so the transceiver points toward this port
  always_ff @(posedge clk) begin
    if (srst) begin
      read_write_dir <= 1'b1;
      xcvr_direction_n <= 1'b0;
    end else if (next_state == MPB_IDLE) begin
      read_write_dir <= 1'b1;
      xcvr_direction_n <= 1'b0;
    end else begin
      read_write_dir <= !nx_write;
      xcvr_direction_n <= nx_write;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      read_output_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      read_output_strobe_n <= !(next_state == MPB_STROBE && !cur.write);
      write_strobe_n <= !(next_state == MPB_STROBE && cur.write);
    end
  end

  // pins stay inputs in cold reset so the boot vector can be read
  always_ff @(posedge clk) begin
    if (srst) begin
      periph_data_oe_n <= 1'b1;
      periph_data_out <= DATA_RESET;
    end else if (cold_reset || next_state == MPB_IDLE) begin
      periph_data_oe_n <= 1'b1;
    end else if (nx_write) begin
      periph_data_oe_n <= 1'b0;
      periph_data_out <= (state == MPB_IDLE) ? req.wdata : cur.wdata;
    end else begin
      periph_data_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      boot_vector <= BOOT_RESET;
      boot_valid <= 1'b0;
    end else if (cold_reset) begin
      boot_vector <= periph_data_in;
      boot_valid <= 1'b0;
    end else begin
      boot_valid <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp <= '0;
    end else if (state == MPB_STROBE && strobe_end) begin
      rsp.rdata <= cur.write ? DATA_RESET : periph_data_in;
      rsp.timeout <= timed_out;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (state == MPB_HOLD) && phase_done;
    end
  end

  logic strobe_on;
  logic sel_on;
  assign strobe_on = !read_output_strobe_n || !write_strobe_n;
  assign sel_on = (device_select_n != CS_IDLE_N);

  sequence strobe_falls_s;
    $rose(strobe_on);
  endsequence

  sequence strobe_drops_s;
    $fell(strobe_on);
  endsequence

  sequence select_opens_s;
    $rose(sel_on);
  endsequence

  read_dir_a: assert property (@(posedge clk) disable iff (srst)
    !read_output_strobe_n |-> read_write_dir && periph_data_oe_n)
    else $error("read strobe without read direction");

  write_dir_a: assert property (@(posedge clk) disable iff (srst)
    !write_strobe_n |-> !read_write_dir && !periph_data_oe_n)
    else $error("write strobe without driven write data");

  strobe_excl_a: assert property (@(posedge clk) disable iff (srst)
    !(!read_output_strobe_n && !write_strobe_n))
    else $error("both strobes asserted");

  select_onehot_a: assert property (@(posedge clk) disable iff (srst)
    $onehot0(~device_select_n) && (!strobe_on || sel_on))
    else $error("select not one-hot or missing under strobe");

  setup_before_a: assert property (@(posedge clk) disable iff (srst)
    select_opens_s |-> !strobe_on [*1] ##1 strobe_on)
    else $error("strobe did not follow setup by one cycle");

  select_hold_a: assert property (@(posedge clk) disable iff (srst)
    strobe_drops_s |-> sel_on ##1 !sel_on)
    else $error("select not held one cycle past strobe");

  wait_extend_a: assert property (@(posedge clk) disable iff (srst)
    state == MPB_STROBE && !wait_is_ack && stretch && !timed_out |=> strobe_on)
    else $error("wait did not extend the strobe");

  ack_end_a: assert property (@(posedge clk) disable iff (srst)
    state == MPB_STROBE && wait_is_ack && stretch |=> !strobe_on ##1 rsp_valid)
    else $error("acknowledge did not end the transaction");

  min_strobe_a: assert property (@(posedge clk) disable iff (srst)
    (strobe_falls_s and !wait_is_ack) |-> strobe_on [*3])
    else $error("strobe shorter than its minimum");

  cold_input_a: assert property (@(posedge clk) disable iff (srst)
    cold_reset |=> periph_data_oe_n && boot_vector == $past(periph_data_in))
    else $error("data pins driven or vector missed in cold reset");

  xcvr_use_a: assert property (@(posedge clk) disable iff (srst)
    (xcvr_output_enable_n == !sel_on) && (!sel_on || xcvr_direction_n == !read_write_dir))
    else $error("transceiver controls disagree with the access");

  // an access never shares a select with the next one, so a held select must not move
  select_stable_a: assert property (@(posedge clk) disable iff (srst)
    sel_on && $past(sel_on) |-> $stable(device_select_n))
    else $error("select changed inside an access");

  wdata_stable_a: assert property (@(posedge clk) disable iff (srst)
    !write_strobe_n |-> $stable(periph_data_out))
    else $error("write data moved under the write strobe");

  addr_stable_a: assert property (@(posedge clk) disable iff (srst)
    strobe_on |-> $stable(periph_address) && $stable(periph_address_hi))
    else $error("address moved under a strobe");
endmodule

// File: design/mpb_pkg.sv
package mpb_pkg;
  localparam int ADDR_W = 22;
  localparam int ADDR_HI_W = 4;
  localparam int DATA_W = 8;
  localparam int CS_COUNT = 4;
  localparam int CS_IDX_W = 2;
  localparam int CNT_W = 11;

  // bus clock and phase lengths in nanoseconds
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETUP_NS = 50;
  localparam int STROBE_NS = 150;
  localparam int HOLD_NS = 50;
  // least times round up, never below one cycle
  localparam int SETUP_CYC_I = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC_I = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC_I = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(SETUP_CYC_I < 1 ? 1 : SETUP_CYC_I);
  localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(STROBE_CYC_I < 1 ? 1 : STROBE_CYC_I);
  localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'(HOLD_CYC_I < 1 ? 1 : HOLD_CYC_I);
  // strobe cycles allowed before an unanswered access is closed with an error
  localparam logic [CNT_W-1:0] TIMEOUT_CYC = 11'h0400;

  localparam logic [CS_COUNT-1:0] CS_IDLE_N = 4'h0 - 4'h1;
  localparam logic [DATA_W-1:0] BOOT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    MPB_IDLE = 2'b00,
    MPB_SETUP = 2'b01,
    MPB_STROBE = 2'b10,
    MPB_HOLD = 2'b11
  } mpb_state_type;

  typedef struct packed {
    logic write;
    logic [CS_IDX_W-1:0] select;
    logic [ADDR_HI_W-1:0] addr_hi;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mpb_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic timeout;
  } mpb_rsp_type;
endpackage

// File: design/mpb_phase_timer.sv
`timescale 1ns/1ps
module mpb_phase_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [mpb_pkg::CNT_W-1:0] length,
  output logic done
);
  import mpb_pkg::*;

  logic [CNT_W-1:0] remaining;

  // a phase of length n lasts n cycles: loaded with n-1, done at zero
  always_ff @(posedge clk) begin
    if (srst) begin
      remaining <= '0;
    end else if (load) begin
      remaining <= length - CNT_W'(1);
    end else if (remaining != '0) begin
      remaining <= remaining - CNT_W'(1);
    end
  end

  assign done = (remaining == '0);
endmodule

// File: bench/mpb_mem_model.sv
`timescale 1ns/1ps
module mpb_mem_model (
  input wire logic clk,
  input wire logic ack_mode,
  input wire logic [10:0] stall,
  input wire logic cold_reset,
  input wire logic [7:0] boot_value,
  input wire logic [3:0] device_select_n,
  input wire logic [21:0] periph_address,
  input wire logic [7:0] periph_data_out,
  input wire logic periph_data_oe_n,
  input wire logic read_output_strobe_n,
  input wire logic write_strobe_n,
  output logic [7:0] periph_data_in,
  output logic stretch_or_done_n
);
  logic [7:0] mem [32];
  logic [7:0] last = 8'h00;
  logic [10:0] cnt = 11'h000;
  logic [1:0] sel;
  logic active;
  logic [4:0] idx;
  always_comb begin
    case (device_select_n)
      4'hd: sel = 2'h1;
      4'hb: sel = 2'h2;
      4'h7: sel = 2'h3;
      default: sel = 2'h0;
    endcase
  end
  assign idx = {sel, periph_address[2:0]};
  // every _n pin is taken as asserted at the low level
  assign active = !read_output_strobe_n || !write_strobe_n;
  // wait mode holds the line low for the first stall strobe cycles, ack mode after them
  assign stretch_or_done_n =
    !(active && (ack_mode ? cnt >= stall : cnt < stall));
  // off the bus the pins show the inverse of the last level, so a stale byte never passes
  assign periph_data_in = cold_reset ? boot_value :
    (!read_output_strobe_n && periph_data_oe_n && device_select_n != 4'hf) ? mem[idx] : ~last;
  always @(posedge clk) last <= periph_data_in;
  always @(posedge clk) cnt <= active ? cnt + 11'h001 : 11'h000;
  always @(posedge clk) begin
    if (!write_strobe_n && device_select_n != 4'hf) begin
      mem[idx] <= periph_data_out;
    end
  end
endmodule

// File: bench/memory_peripheral_bus_port_test.sv
`timescale 1ns/1ps
module memory_peripheral_bus_port_test;
  import mpb_pkg::*;
  `define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
  typedef struct packed {
    logic write; logic [1:0] sel; logic [21:0] addr; logic [3:0] hi;
    logic [7:0] wdata; logic ack; logic [10:0] stall; logic [7:0] exp;
  } mpb_row_type;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic cold_reset = 1'h0;
  logic wait_is_ack = 1'h0;
  logic req_valid = 1'h0;
  mpb_req_type req = '0;
  logic [10:0] stall = 11'h000;
  logic [7:0] boot_value = 8'h00;
  logic req_ready, rsp_valid, boot_valid, periph_data_oe_n, read_write_dir;
  logic read_output_strobe_n, write_strobe_n, xcvr_direction_n, xcvr_output_enable_n;
  logic stretch_or_done_n;
  mpb_rsp_type rsp;
  logic [7:0] boot_vector, periph_data_in, periph_data_out;
  logic [3:0] device_select_n, periph_address_hi;
  logic [21:0] periph_address;
  logic [8:0] pin_view;
  assign pin_view = {device_select_n, read_output_strobe_n, write_strobe_n, xcvr_output_enable_n,
    read_write_dir, rsp_valid};
  int fail_count = 0;
  int checks_done = 0;
  mpb_row_type rows [8] = '{
    '{1'h1, 2'h0, 22'h00_0001, 4'h1, 8'h55, 1'h0, 11'h000, 8'h00},
    '{1'h1, 2'h1, 22'h3f_fff2, 4'hf, 8'ha3, 1'h0, 11'h005, 8'h00},
    '{1'h1, 2'h2, 22'h00_0003, 4'h0, 8'h3c, 1'h1, 11'h000, 8'h00},
    '{1'h1, 2'h3, 22'h2a_aaa4, 4'h5, 8'hc7, 1'h1, 11'h002, 8'h00},
    '{1'h0, 2'h0, 22'h00_0001, 4'h1, 8'h00, 1'h1, 11'h001, 8'h55},
    '{1'h0, 2'h1, 22'h3f_fff2, 4'hf, 8'h00, 1'h0, 11'h000, 8'ha3},
    '{1'h0, 2'h2, 22'h00_0003, 4'h0, 8'h00, 1'h0, 11'h004, 8'h3c},
    '{1'h0, 2'h3, 22'h2a_aaa4, 4'h5, 8'h00, 1'h1, 11'h000, 8'hc7}};
  always #25 clk = ~clk;
  mpb_port dut_u (.clk(clk), .srst(srst), .cold_reset(cold_reset), .wait_is_ack(wait_is_ack),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .boot_vector(boot_vector), .boot_valid(boot_valid), .device_select_n(device_select_n),
    .periph_address(periph_address), .periph_address_hi(periph_address_hi),
    .periph_data_in(periph_data_in), .periph_data_out(periph_data_out),
    .periph_data_oe_n(periph_data_oe_n), .read_write_dir(read_write_dir),
    .read_output_strobe_n(read_output_strobe_n), .write_strobe_n(write_strobe_n),
    .xcvr_direction_n(xcvr_direction_n), .xcvr_output_enable_n(xcvr_output_enable_n),
    .stretch_or_done_n(stretch_or_done_n));
  mpb_mem_model mem_u (.clk(clk), .ack_mode(wait_is_ack), .stall(stall),
    .cold_reset(cold_reset), .boot_value(boot_value), .device_select_n(device_select_n),
    .periph_address(periph_address), .periph_data_out(periph_data_out),
    .periph_data_oe_n(periph_data_oe_n), .read_output_strobe_n(read_output_strobe_n),
    .write_strobe_n(write_strobe_n), .periph_data_in(periph_data_in),
    .stretch_or_done_n(stretch_or_done_n));
  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one whole access; pins are compared in every strobe cycle, the answer at its pulse
  task automatic run(input mpb_row_type r);
    int n;
    int strobes;
    int exp_len;
    logic tmo;
    tmo = r.ack && r.stall >= 11'h400;
    exp_len = r.ack ? r.stall + 1 : (r.stall > 2 ? r.stall + 1 : 3);
    n = 0;
    strobes = 0;
    @(posedge clk);
    req_valid <= 1'h1;
    req <= '{r.write, r.sel, r.hi, r.addr, r.wdata};
    wait_is_ack <= r.ack;
    stall <= r.stall;
    do @(negedge clk); while (req_ready !== 1'h1 && ++n < 100);
    @(posedge clk);
    req_valid <= 1'h0;
    n = 0;
    while (n < 1100) begin
      @(negedge clk);
      n++;
      if (rsp_valid === 1'h1) break;
      if (!read_output_strobe_n || !write_strobe_n) begin
        strobes++;
        `CHK("select", ~(4'h1 << r.sel), device_select_n)
        `CHK("rw", !r.write, read_write_dir)
        `CHK("xdir", r.write, xcvr_direction_n)
        `CHK("xoe", 1'h0, xcvr_output_enable_n)
        `CHK("addr", {r.hi, r.addr}, {periph_address_hi, periph_address})
        `CHK("rd_strobe", r.write, read_output_strobe_n)
        `CHK("wr_strobe", !r.write, write_strobe_n)
        `CHK("data_oe", !r.write, periph_data_oe_n)
        if (r.write) `CHK("wdata", r.wdata, periph_data_out)
      end
    end
    `CHK("done", 1'h1, rsp_valid)
    `CHK("idle", 5'h1f, {device_select_n, xcvr_output_enable_n})
    `CHK("timeout", tmo, rsp.timeout)
    if (!tmo) begin
      `CHK("rdata", r.exp, rsp.rdata)
      `CHK("strobe_len", exp_len, strobes)
      `CHK("latency", exp_len + 3, n)
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    `CHK("rst_pins", 9'h1fe, pin_view)
    @(posedge clk);
    srst <= 1'h0;
    cold_reset <= 1'h1;
    boot_value <= 8'ha5;
    repeat (3) @(negedge clk);
    `CHK("boot_a", 11'h52a, {boot_vector, req_ready, periph_data_oe_n, boot_valid})
    @(posedge clk);
    boot_value <= 8'h3c;
    @(posedge clk);
    cold_reset <= 1'h0;
    @(negedge clk);
    `CHK("boot_b", 8'h3c, boot_vector)
    @(negedge clk);
    `CHK("boot_c", 10'h0f3, {boot_vector, boot_valid, req_ready})
    foreach (rows[i]) run(rows[i]);
    // acknowledge never comes: the access must close itself with the error flag
    run('{1'h0, 2'h2, 22'h00_0003, 4'h0, 8'h00, 1'h1, 11'h7ff, 8'h00});
    run(rows[6]);
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule
